// [src/rtu_defines.vh]
`ifndef RTU_DEFINES_VH
`define RTU_DEFINES_VH

// ****************************************************************
// Opcode patterns.
// ****************************************************************
`define RTU_INTRET_PAT 16'h0010
`define RTU_INTRET_MASK 16'hFFFE
`define RTU_LITRET_PAT 16'h0C00
`define RTU_LITRET_MASK 16'hFF00
`define RTU_SHADOW_BIT 0
`define RTU_LIT_LSB 0
`define RTU_LIT_MSB 7

// ****************************************************************
// Register byte addresses.
// ****************************************************************
`define RTU_A_INSTR 8'h00
`define RTU_A_STAT 8'h04
`define RTU_A_W 8'h08
`define RTU_A_STATUS 8'h0C
`define RTU_A_BANK 8'h10
`define RTU_A_WSH 8'h14
`define RTU_A_STSH 8'h18
`define RTU_A_BANKSH 8'h1C
`define RTU_A_TOP 8'h20
`define RTU_A_PC 8'h24
`define RTU_A_LATCH 8'h28
`define RTU_A_INTCTL 8'h2C
`define RTU_A_DEPTH 8'h30

// ****************************************************************
// Field positions and widths.
// ****************************************************************
`define RTU_PC_W 21
`define RTU_DEPTH_W 5
`define RTU_LATHI_LSB 0
`define RTU_LATHI_MSB 7
`define RTU_LATUP_LSB 8
`define RTU_LATUP_MSB 12
`define RTU_INT_HI 0
`define RTU_INT_LO 1
`define RTU_INT_SEL 2
`define RTU_ST_BUSY 0
`define RTU_ST_UNDER 1
`define RTU_ST_BADOP 2
`define RTU_ST_PH_LSB 4
`define RTU_ST_PH_MSB 5

// ****************************************************************
// Phases, states, responses and reset values.
// ****************************************************************
`define RTU_Q1 2'h0
`define RTU_Q4 2'h3
`define RTU_S_IDLE 2'h0
`define RTU_S_EXEC 2'h1
`define RTU_S_FLUSH 2'h2
`define RTU_RESP_OK 2'h0
`define RTU_RESP_ERR 2'h2
`define RTU_RST8 8'h00
`define RTU_RST16 16'h0000
`define RTU_RST32 32'h00000000

`endif

// [src/rtu_phase_gen.v]
`timescale 1ns/100ps
`default_nettype none
`include "rtu_defines.vh"

// ****************************************************************
// Four-phase instruction clock generator.
// ****************************************************************
module rtu_phase_gen
(
    input wire ref_clk,
    input wire rstn,
    output wire [1:0] phase,
    output wire lastPhase
);

reg [1:0] phaseFF;

// The phase counter steps Q1 to Q4 on every rising edge.
always @(posedge ref_clk)
begin
    if (!rstn)
        phaseFF <= `RTU_Q1;
    else
        phaseFF <= phaseFF + 2'h1;
end

// Q4 marks the end of an instruction cycle.
assign phase = phaseFF;
assign lastPhase = (phaseFF == `RTU_Q4);

endmodule
`default_nettype wire

// [src/rtu_op_decode.v]
`timescale 1ns/100ps
`default_nettype none
`include "rtu_defines.vh"

// ****************************************************************
// Decoder for the two return instructions.
// ****************************************************************
module rtu_op_decode
(
    input wire [15:0] opcode,
    output wire isIntReturn,
    output wire isLitReturn,
    output wire shadowFlag,
    output wire [7:0] literal
);

// Compare the fixed opcode bits and split out the operand fields.
assign isIntReturn = ((opcode & `RTU_INTRET_MASK) == `RTU_INTRET_PAT);
assign isLitReturn = ((opcode & `RTU_LITRET_MASK) == `RTU_LITRET_PAT);
assign shadowFlag = opcode[`RTU_SHADOW_BIT];
assign literal = opcode[`RTU_LIT_MSB:`RTU_LIT_LSB];

endmodule
`default_nettype wire

// [src/rtu_return_unit.v]
`timescale 1ns/100ps
`default_nettype none
`include "rtu_defines.vh"

// ****************************************************************
// Return instruction unit with an AXI4-Lite register slave.
// ****************************************************************
module rtu_return_unit
(
    input wire ref_clk,
    input wire rstn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg stackPop
);

wire [1:0] phase;
wire lastPhase;
wire isIntReturn;
wire isLitReturn;
wire shadowFlag;
wire [7:0] literal;

reg [7:0] awAddrFF;
reg [31:0] wDataFF;
reg [3:0] wStrbFF;
reg awHeldFF;
reg wHeldFF;
reg [7:0] wFF;
reg [7:0] statusFF;
reg [7:0] bankFF;
reg [7:0] wShFF;
reg [7:0] stShFF;
reg [7:0] bankShFF;
reg [`RTU_PC_W-1:0] topFF;
reg [`RTU_PC_W-1:0] pcFF;
reg [12:0] latchFF;
reg hiEnFF;
reg loEnFF;
reg leaveLowFF;
reg [`RTU_DEPTH_W-1:0] depthFF;
reg underFF;
reg badOpFF;
reg [15:0] opcodeFF;
reg pendFF;
reg [1:0] stateFF;
reg [1:0] nxt_state;
reg [31:0] rdMux;
reg rdErr;
reg wrHit;

wire doWrite = awHeldFF & wHeldFF & ~s_axi_bvalid;
wire execQ4 = (stateFF == `RTU_S_EXEC) & lastPhase;
wire busy = pendFF | (stateFF != `RTU_S_IDLE);

// Byte-lane merge of write data into an existing word.
function [31:0] wmerge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer i;
    begin
        wmerge = old;
        for (i = 0; i < 4; i = i + 1)
        begin
            if (s[i])
                wmerge[i*8 +: 8] = d[i*8 +: 8];
        end
    end
endfunction

// Merged words, cut to each register's width where they are stored.
wire [31:0] mOp = wmerge({16'h0000, opcodeFF}, wDataFF, wStrbFF);
wire [31:0] mW = wmerge({24'h000000, wFF}, wDataFF, wStrbFF);
wire [31:0] mTop = wmerge({11'h000, topFF}, wDataFF, wStrbFF);
wire [31:0] mLatch = wmerge({19'h00000, latchFF}, wDataFF, wStrbFF);

// ****************************************************************
// Submodules.
// ****************************************************************
rtu_phase_gen u_phase
(
    .ref_clk(ref_clk),
    .rstn(rstn),
    .phase(phase),
    .lastPhase(lastPhase)
);

rtu_op_decode u_decode
(
    .opcode(opcodeFF),
    .isIntReturn(isIntReturn),
    .isLitReturn(isLitReturn),
    .shadowFlag(shadowFlag),
    .literal(literal)
);

// ****************************************************************
// AXI4-Lite write channels.
// ****************************************************************

// Address and data are held separately and may arrive in any order.
always @(posedge ref_clk)
begin
    if (!rstn)
    begin
        awHeldFF <= 1'b0;
        wHeldFF <= 1'b0;
        awAddrFF <= `RTU_RST8;
        wDataFF <= `RTU_RST32;
        wStrbFF <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RTU_RESP_OK;
    end
    else
    begin
        s_axi_awready <= ~awHeldFF & ~s_axi_awready & s_axi_awvalid;
        s_axi_wready <= ~wHeldFF & ~s_axi_wready & s_axi_wvalid;
        if (s_axi_awvalid & s_axi_awready)
        begin
            awHeldFF <= 1'b1;
            awAddrFF <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready)
        begin
            wHeldFF <= 1'b1;
            wDataFF <= s_axi_wdata;
            wStrbFF <= s_axi_wstrb;
        end
        if (doWrite)
        begin
            awHeldFF <= 1'b0;
            wHeldFF <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? `RTU_RESP_OK : `RTU_RESP_ERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end
end

// Writable addresses answer OKAY, all others SLVERR.
always @*
begin
    case (awAddrFF)
        `RTU_A_INSTR, `RTU_A_STAT, `RTU_A_W, `RTU_A_STATUS,
        `RTU_A_BANK, `RTU_A_WSH, `RTU_A_STSH, `RTU_A_BANKSH,
        `RTU_A_TOP, `RTU_A_LATCH, `RTU_A_INTCTL, `RTU_A_DEPTH:
            wrHit = 1'b1;
        default:
            wrHit = 1'b0;
    endcase
end

// ****************************************************************
// AXI4-Lite read channels.
// ****************************************************************

// Read multiplexer over all registers.
always @*
begin
    rdMux = `RTU_RST32;
    rdErr = 1'b0;
    case (s_axi_araddr)
        `RTU_A_INSTR: rdMux[15:0] = opcodeFF;
        `RTU_A_STAT:
        begin
            rdMux[`RTU_ST_BUSY] = busy;
            rdMux[`RTU_ST_UNDER] = underFF;
            rdMux[`RTU_ST_BADOP] = badOpFF;
            rdMux[`RTU_ST_PH_MSB:`RTU_ST_PH_LSB] = phase;
        end
        `RTU_A_W: rdMux[7:0] = wFF;
        `RTU_A_STATUS: rdMux[7:0] = statusFF;
        `RTU_A_BANK: rdMux[7:0] = bankFF;
        `RTU_A_WSH: rdMux[7:0] = wShFF;
        `RTU_A_STSH: rdMux[7:0] = stShFF;
        `RTU_A_BANKSH: rdMux[7:0] = bankShFF;
        `RTU_A_TOP: rdMux[`RTU_PC_W-1:0] = topFF;
        `RTU_A_PC: rdMux[`RTU_PC_W-1:0] = pcFF;
        `RTU_A_LATCH: rdMux[12:0] = latchFF;
        `RTU_A_INTCTL:
        begin
            rdMux[`RTU_INT_HI] = hiEnFF;
            rdMux[`RTU_INT_LO] = loEnFF;
            rdMux[`RTU_INT_SEL] = leaveLowFF;
        end
        `RTU_A_DEPTH: rdMux[`RTU_DEPTH_W-1:0] = depthFF;
        default: rdErr = 1'b1;
    endcase
end

// One read at a time; data is registered one cycle after the address.
always @(posedge ref_clk)
begin
    if (!rstn)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= `RTU_RST32;
        s_axi_rresp <= `RTU_RESP_OK;
    end
    else
    begin
        s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
        if (s_axi_arvalid & s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdErr ? `RTU_RESP_ERR : `RTU_RESP_OK;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end

// ****************************************************************
// Instruction sequencer.
// ****************************************************************

// Idle waits for a cycle boundary, then one execute and one flush cycle.
always @*
begin
    nxt_state = stateFF;
    case (stateFF)
        `RTU_S_IDLE:
            if (pendFF & lastPhase)
                nxt_state = `RTU_S_EXEC;
        `RTU_S_EXEC:
            if (lastPhase)
                nxt_state = `RTU_S_FLUSH;
        `RTU_S_FLUSH:
            if (lastPhase)
                nxt_state = `RTU_S_IDLE;
        default:
            nxt_state = `RTU_S_IDLE;
    endcase
end

// State register and the pop strobe, which lasts one Q4 edge.
always @(posedge ref_clk)
begin
    if (!rstn)
    begin
        stateFF <= `RTU_S_IDLE;
        stackPop <= 1'b0;
    end
    else
    begin
        stateFF <= nxt_state;
        stackPop <= execQ4 & (isIntReturn | isLitReturn);
    end
end

// ****************************************************************
// Core registers: software writes first, execution overrides.
// ****************************************************************
always @(posedge ref_clk)
begin
    if (!rstn)
    begin
        wFF <= `RTU_RST8;
        statusFF <= `RTU_RST8;
        bankFF <= `RTU_RST8;
        wShFF <= `RTU_RST8;
        stShFF <= `RTU_RST8;
        bankShFF <= `RTU_RST8;
        topFF <= {`RTU_PC_W{1'b0}};
        pcFF <= {`RTU_PC_W{1'b0}};
        latchFF <= 13'h0000;
        hiEnFF <= 1'b0;
        loEnFF <= 1'b0;
        leaveLowFF <= 1'b0;
        depthFF <= {`RTU_DEPTH_W{1'b0}};
        underFF <= 1'b0;
        badOpFF <= 1'b0;
        opcodeFF <= `RTU_RST16;
        pendFF <= 1'b0;
    end
    else
    begin
        if (doWrite)
        begin
            case (awAddrFF)
                `RTU_A_INSTR:
                    if (!busy)
                    begin
                        opcodeFF <= mOp[15:0];
                        pendFF <= 1'b1;
                    end
                `RTU_A_STAT:
                begin
                    // Write one to clear the sticky error flags.
                    if (wStrbFF[0] & wDataFF[`RTU_ST_UNDER])
                        underFF <= 1'b0;
                    if (wStrbFF[0] & wDataFF[`RTU_ST_BADOP])
                        badOpFF <= 1'b0;
                end
                `RTU_A_W: wFF <= mW[7:0];
                `RTU_A_STATUS:
                    statusFF <= wStrbFF[0] ? wDataFF[7:0] : statusFF;
                `RTU_A_BANK:
                    bankFF <= wStrbFF[0] ? wDataFF[7:0] : bankFF;
                `RTU_A_WSH:
                    wShFF <= wStrbFF[0] ? wDataFF[7:0] : wShFF;
                `RTU_A_STSH:
                    stShFF <= wStrbFF[0] ? wDataFF[7:0] : stShFF;
                `RTU_A_BANKSH:
                    bankShFF <= wStrbFF[0] ? wDataFF[7:0] : bankShFF;
                `RTU_A_TOP:
                    topFF <= mTop[`RTU_PC_W-1:0];
                `RTU_A_LATCH:
                    latchFF <= mLatch[12:0];
                `RTU_A_INTCTL:
                    if (wStrbFF[0])
                    begin
                        hiEnFF <= wDataFF[`RTU_INT_HI];
                        loEnFF <= wDataFF[`RTU_INT_LO];
                        leaveLowFF <= wDataFF[`RTU_INT_SEL];
                    end
                `RTU_A_DEPTH:
                    depthFF <= wStrbFF[0] ? wDataFF[`RTU_DEPTH_W-1:0]
                                          : depthFF;
                default:
                    pendFF <= pendFF;
            endcase
        end
        // The pending request is consumed at the decode cycle boundary.
        if ((stateFF == `RTU_S_IDLE) & pendFF & lastPhase)
            pendFF <= 1'b0;
        // Q4 of the execute cycle: pop, load and restore.
        if (execQ4)
        begin
            if (isIntReturn | isLitReturn)
            begin
                pcFF <= topFF;
                // Latches are never loaded here.
                if (depthFF == {`RTU_DEPTH_W{1'b0}})
                    underFF <= 1'b1;
                else
                    depthFF <= depthFF - {{(`RTU_DEPTH_W-1){1'b0}}, 1'b1};
            end
            else
                badOpFF <= 1'b1;
            if (isIntReturn)
            begin
                if (leaveLowFF)
                    loEnFF <= 1'b1;
                else
                    hiEnFF <= 1'b1;
                if (shadowFlag)
                begin
                    wFF <= wShFF;
                    statusFF <= stShFF;
                    bankFF <= bankShFF;
                end
                // A clear flag leaves W, status and bank alone.
            end
            if (isLitReturn)
                wFF <= literal;
        end
    end
end

endmodule
`default_nettype wire

// [src/rtu_unused_guard.v]
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [verif/rtu_return_unit_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rtu_defines.vh"

// ****************************************
// Port checks of the return unit.
// ****************************************
module rtu_return_unit_asserts
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stackPop
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // Both halves of a write to the instruction register are taken together.
    wire logic instrTake = s_axi_awvalid && s_axi_awready
        && s_axi_awaddr == `RTU_A_INSTR && s_axi_wvalid && s_axi_wready;

    // Steps of an instruction: the opcode write, then one pop pulse.
    sequence retWrite;
        instrTake && (s_axi_wdata[15:1] == 15'h0008
            || s_axi_wdata[15:8] == 8'h0C);
    endsequence
    sequence badWrite;
        instrTake && s_axi_wdata[15:0] == 16'h0013;
    endsequence
    sequence popSeq;
        stackPop ##1 (!stackPop) [*7];
    endsequence

    AST_POP_TIMING: assert property (
        retWrite |-> ##[6:11] stackPop)
        else $error("no stack pop after a return opcode");
    AST_POP_PULSE: assert property (stackPop |-> popSeq)
        else $error("stack pop is not a lone pulse");
    AST_NO_POP_BAD: assert property (
        badWrite |=> (!stackPop) [*8] ##1 (!stackPop) [*4])
        else $error("stack popped by a foreign opcode");
    AST_PC_READONLY: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_awaddr == `RTU_A_PC |-> ##[1:3] (s_axi_bvalid
        && s_axi_bresp == `RTU_RESP_ERR))
        else $error("program counter write not refused");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped early");
    AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr > `RTU_A_DEPTH |=> s_axi_rresp == `RTU_RESP_ERR
        && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
endmodule

bind rtu_return_unit rtu_return_unit_asserts rtu_return_unit_asserts_i (.*);
`default_nettype wire

// [verif/rtu_fetch_model.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Fetch side: an AXI4-Lite master issuing transfers.
// ****************************************
module rtu_fetch_model
(
    input wire logic ref_clk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    int timeouts = 0;

    // The bus is idle at time zero.
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
    end

    // A write: address and data offered together, each freed when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        int n;
        logic b;
        n = 0;
        b = 1'b0;
        r = 2'h3;
        @(posedge ref_clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!b && n < 50)
        begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awready)
                {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (s_axi_wready)
                {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
            if (s_axi_bvalid)
            begin
                b = 1'b1;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        if (!b)
            timeouts++;
    endtask

    // A read: the data are taken at the edge where rvalid is seen.
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        d = 32'h0;
        r = 2'h3;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (!got && n < 50)
        begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arready)
                {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
            if (s_axi_rvalid)
            begin
                got = 1'b1;
                {d, r} = {s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'b0;
            end
        end
        if (!got)
            timeouts++;
    endtask
endmodule
`default_nettype wire

// [verif/test_return_instruction_unit.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rtu_defines.vh"

// ****************************************
// Self-checking bench of the return unit.
// ****************************************
module test_return_instruction_unit;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, stackPop;
    int error_cnt = 0;
    int checks = 0;
    int pops = 0;
    int m [13];
    int msk [13] = '{32'hFFFF, 32'h0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 21'h1FFFFF, 21'h1FFFFF, 13'h1FFF, 3'h7, 5'h1F};

    rtu_return_unit rtu_return_unit_i (.*);
    rtu_fetch_model rtu_fetch_model_i (.*);

    // Clock of 100 MHz and a count of the pop pulses.
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (stackPop === 1'b1)
            pops++;

    // Comparison of values and of bus responses.
    task automatic cmpVal(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmpResp(input string what, input logic [1:0] exp,
        input logic [1:0] got);
        cmpVal(what, {30'h0, exp}, {30'h0, got});
    endtask

    // Bus wrappers that end the run when a transfer hangs.
    task automatic wr(input int a, input int d, output logic [1:0] r);
        rtu_fetch_model_i.wr(8'(a), 32'(d), r);
        if (rtu_fetch_model_i.timeouts != 0)
            end_of_test();
    endtask
    task automatic rd(input int a, output logic [31:0] d,
        output logic [1:0] r);
        rtu_fetch_model_i.rd(8'(a), d, r);
        if (rtu_fetch_model_i.timeouts != 0)
            end_of_test();
    endtask

    task automatic end_of_test();
        error_cnt += rtu_fetch_model_i.timeouts;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Reset values, refusals, then random setups with each opcode kind.
    initial
    begin
        logic [1:0] r;
        logic [31:0] d;
        logic [15:0] op;
        logic [7:0] k;
        logic under, bad;
        int expPops, n;
        {under, bad, expPops} = '0;
        void'($urandom(43));
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int a = 0; a < 13; a++)
        begin
            rd(4 * a, d, r);
            d[5:4] = (a == 1) ? 2'h0 : d[5:4];
            cmpVal($sformatf("reset reg %0h", 4 * a), 32'h0, d);
        end
        rd(8'h34, d, r);
        cmpResp("unmapped read", `RTU_RESP_ERR, r);
        wr(8'h24, 32'h1, r);
        cmpResp("pc write", `RTU_RESP_ERR, r);
        wr(8'h40, 32'h1, r);
        cmpResp("unmapped write", `RTU_RESP_ERR, r);
        for (int i = 0; i < 16; i++)
        begin
            for (int a = 2; a < 13; a++)
                if (a != 9)
                begin
                    m[a] = (a == 12) ? $urandom % 3 : $urandom & msk[a];
                    wr(4 * a, m[a], r);
                end
            k = 8'($urandom);
            op = (i % 4 == 2) ? {8'h0C, k} : 16'h0010 + 16'(i % 4);
            m[0] = op;
            if (i % 4 != 3)
            begin
                expPops++;
                m[9] = m[8];
                under = under | (m[12] == 0);
                m[12] = (m[12] == 0) ? 0 : m[12] - 1;
                if (i % 4 == 2)
                    m[2] = k;
                else
                    m[11] = m[11] | (((m[11] & 4) != 0) ? 2 : 1);
                if (i % 4 == 1)
                    {m[2], m[3], m[4]} = {m[5], m[6], m[7]};
            end
            else
                bad = 1'b1;
            wr(`RTU_A_INSTR, op, r);
            cmpResp("instr write", `RTU_RESP_OK, r);
            d = 32'h1;
            for (n = 0; n < 20 && d[0] !== 1'b0; n++)
                rd(`RTU_A_STAT, d, r);
            cmpVal("busy", 32'h0, {31'h0, d[0]});
            cmpVal("flags", {29'h0, bad, under, 1'b0}, {29'h0, d[2:0]});
            for (int a = 0; a < 13; a++)
                if (a != 1)
                begin
                    rd(4 * a, d, r);
                    cmpVal($sformatf("reg %0h", 4 * a), m[a], d);
                end
            cmpVal("pop count", expPops, pops);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
